// File: flash_id_reset_command_unit.sv
// Identification, reset and information-row command unit of a serial flash
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Signature read waits three dummy bytes first
// - Signature byte repeats MSB first, falling edges
// - Identifier read sends maker then type/capacity
// - Identifier sequence loops while select low
// - Address bit zero picks first code
// - Maker and device codes alternate until deselect
// - Serial number after address and dummy clocks
// - Serial number repeats every 16 bytes
// - Serial address bits 8:4 zero, 3:0 start
// - Discovery table after address and dummy
// - No-operation only cancels reset arm
// - Reset needs arm frame directly before
// - Reset reloads volatile state, soft keeps locks
// - Shared pin resets only serial, quad off
// - Pin low minimum width aborts and silences
// - Reset aborts write, longer recovery then
// - Row program refused while write busy
// - Four rows at middle byte 00/10/20/30
// - Locked row never accepts program
// - Signature or wake refused while busy
// - Pin select bit picks hold or reset
module flash_id_reset_command_unit
    import flash_id_pkg::*;
#(
    parameter logic [7:0]   MAKER_CODE         = 8'h5c,  // Arbitrary value
    parameter logic [7:0]   DEVICE_CODE        = 8'h2e,  // Arbitrary value
    parameter logic [15:0]  TYPE_CAPACITY      = 16'h4321, // Arbitrary value
    parameter logic [127:0] SERIAL_NUMBER      = 128'h00112233445566778899aabbccddeeff,
    parameter int           ABORT_RECOVERY_CYC = 7000
) (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    // Link
    input  wire logic       i_sclk,
    input  wire logic       i_cs_n,
    input  wire logic [3:0] i_io_in,
    output logic      [3:0] o_io_out,
    output logic      [3:0] o_io_oe,
    input  wire logic       i_reset_pin_n,
    input  wire logic       i_hold_reset_pin_n,
    // Configuration and state of the rest of the device
    input  wire logic       i_quad_mode,
    input  wire logic       i_quad_enable,
    input  wire logic       i_pin_function_select,
    input  wire logic       i_dedicated_reset_disable,
    input  wire logic       i_write_in_progress,
    input  wire logic [3:0] i_dummy_cycles,
    input  wire logic [3:0] i_info_row_lock,
    // Events and state
    output logic            o_reset_armed,
    output logic            o_sw_reset,
    output logic            o_hw_reset,
    output logic            o_reload_volatile,
    output logic            o_reload_locks,
    output logic            o_abort_write,
    output logic            o_recovery,
    output logic            o_pd_release,
    output logic            o_info_prog_start,
    output logic            o_info_prog_reject,
    output logic      [1:0] o_info_row,
    output logic      [7:0] o_info_byte_addr
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic        cs_s1, cs_s2, cs_d;
    logic        tog_s1, tog_s2, tog_seen;
    logic [1:0]  pin_s1, pin_s2;
    logic [3:0]  low_cnt;
    logic [15:0] rec_cnt;
    logic        rec_long;
    logic        cfg_quad, cfg_busy, cfg_refuse;
    logic [6:0]  cfg_dummy;
    logic [6:0]  clk_cnt;
    logic [23:0] shin;
    logic [7:0]  opcode;
    logic        op_tog;
    logic        out_on;
    logic [2:0]  bit_ptr;
    logic [3:0]  byte_idx;

    // ------------------------------------------------------------
    // Stream decoding functions
    // ------------------------------------------------------------
    // Last byte index of the output stream of a command
    function automatic logic [3:0] last_of(input logic [7:0] op);
        unique case (op)
            OP_SIGNATURE:            last_of = LEN_SIG - 4'h1;
            OP_IDENT, OP_IDENT_QUAD: last_of = LEN_IDENT - 4'h1;
            OP_MAKER_DEV:            last_of = LEN_MD - 4'h1;
            default:                 last_of = LEN_16;
        endcase
    endfunction : last_of

    // Byte at a stream position
    function automatic logic [7:0] byte_of(input logic [7:0] op, input logic [3:0] idx);
        logic [6:0] sel;
        sel = {idx, 3'h0};
        unique case (op)
            OP_SIGNATURE:            byte_of = DEVICE_CODE;
            OP_IDENT, OP_IDENT_QUAD: byte_of = (idx == 4'h0) ? MAKER_CODE :
                                               (idx == 4'h1) ? TYPE_CAPACITY[15:8] :
                                                               TYPE_CAPACITY[7:0];
            OP_MAKER_DEV:            byte_of = idx[0] ? DEVICE_CODE : MAKER_CODE;
            OP_SERIAL:               byte_of = SERIAL_NUMBER[7'h7f - sel -: 8];
            default:                 byte_of = DISC_TABLE[idx];
        endcase
    endfunction : byte_of

    // ------------------------------------------------------------
    // Main clock: synchronisers
    // ------------------------------------------------------------
    // Select, command toggle and reset pins into the main clock
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cs_s1  <= 1'b1;
            cs_s2  <= 1'b1;
            cs_d   <= 1'b1;
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            pin_s1 <= 2'h3;
            pin_s2 <= 2'h3;
        end else begin
            cs_s1  <= i_cs_n;
            cs_s2  <= cs_s1;
            cs_d   <= cs_s2;
            tog_s1 <= op_tog;
            tog_s2 <= tog_s1;
            pin_s1 <= {i_reset_pin_n, i_hold_reset_pin_n};
            pin_s2 <= pin_s1;
        end
    end

    // ------------------------------------------------------------
    // Main clock: command decode at frame end
    // ------------------------------------------------------------
    // Opcode and address are stable while select is high
    wire frame_end  = cs_s2 & ~cs_d;
    wire cmd_end    = frame_end & (tog_s2 != tog_seen);
    wire accept     = cmd_end & ~o_recovery;
    wire write_in_progress_flag        = i_write_in_progress;
    wire is_arm     = opcode == OP_ARM;
    wire sw_fire    = accept & o_reset_armed & (opcode == OP_RESET);
    wire row_ok     = (shin[23:ROW_TOP_LO] == 8'h00) & (shin[15:14] == 2'h0)
                      & (shin[ROW_GAP_HI:ROW_GAP_LO] == 4'h0);
    wire [1:0] row  = shin[ROW_SEL_HI:ROW_SEL_LO];
    wire prog       = accept & (opcode == OP_ROW_PROG);
    wire prog_ok    = prog & ~write_in_progress_flag & row_ok & ~i_info_row_lock[row];

    // ------------------------------------------------------------
    // Main clock: hardware reset pin
    // ------------------------------------------------------------
    // Shared pin counts only when selected, serial mode, quad off
    wire pin_low    = (~pin_s2[1] & ~i_dedicated_reset_disable)
                      | (~pin_s2[0] & i_pin_function_select
                         & ~i_quad_mode & ~i_quad_enable);
    wire next_hw    = pin_low & (low_cnt >= 4'(HW_RESET_MIN_CYC - 1));
    wire hw_fire    = next_hw & ~o_hw_reset;
    wire reset_evt  = sw_fire | hw_fire;
    wire [15:0] rec_len_now = write_in_progress_flag ? 16'(ABORT_RECOVERY_CYC) : 16'(RECOVERY_CYC);
    wire [15:0] rec_len_old = rec_long ? 16'(ABORT_RECOVERY_CYC) : 16'(RECOVERY_CYC);
    wire [15:0] next_rec    = reset_evt  ? rec_len_now :
                              o_hw_reset ? rec_len_old :
                              (rec_cnt != 16'h0000) ? rec_cnt - 16'h0001 : rec_cnt;

    // Pin low width counter and recovery timer
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            low_cnt  <= 4'h0;
            rec_cnt  <= 16'h0000;
            rec_long <= 1'b0;
        end else begin
            low_cnt  <= !pin_low ? 4'h0 : next_hw ? low_cnt : low_cnt + 4'h1;
            rec_cnt  <= next_rec;
            rec_long <= reset_evt ? write_in_progress_flag : rec_long;
        end
    end

    // ------------------------------------------------------------
    // Main clock: event and status outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            tog_seen           <= 1'b0;
            o_reset_armed      <= 1'b0;
            o_sw_reset         <= 1'b0;
            o_hw_reset         <= 1'b0;
            o_reload_volatile  <= 1'b0;
            o_reload_locks     <= 1'b0;
            o_abort_write      <= 1'b0;
            o_recovery         <= 1'b0;
            o_pd_release       <= 1'b0;
            o_info_prog_start  <= 1'b0;
            o_info_prog_reject <= 1'b0;
            o_info_row         <= 2'h0;
            o_info_byte_addr   <= 8'h00;
        end else begin
            tog_seen           <= frame_end ? tog_s2 : tog_seen;
            // Any accepted command other than arm disarms
            o_reset_armed      <= reset_evt ? 1'b0 :
                                  accept ? is_arm : o_reset_armed;
            o_sw_reset         <= sw_fire;
            o_hw_reset         <= next_hw;
            o_reload_volatile  <= reset_evt;
            o_reload_locks     <= hw_fire;
            o_abort_write      <= reset_evt & write_in_progress_flag;
            o_recovery         <= next_hw | (next_rec != 16'h0000);
            o_pd_release       <= accept & (opcode == OP_SIGNATURE) & ~write_in_progress_flag;
            o_info_prog_start  <= prog_ok;
            o_info_prog_reject <= prog & ~prog_ok;
            o_info_row         <= prog ? row : o_info_row;
            o_info_byte_addr   <= prog ? shin[7:0] : o_info_byte_addr;
        end
    end

    // Settings for the link, frozen while a frame runs
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg_quad   <= 1'b0;
            cfg_busy   <= 1'b0;
            cfg_refuse <= 1'b0;
            cfg_dummy  <= DUMMY_DEFAULT;
        end else if (cs_s2) begin
            cfg_quad   <= i_quad_mode;
            cfg_busy   <= write_in_progress_flag;
            cfg_refuse <= o_recovery;
            cfg_dummy  <= (i_dummy_cycles == 4'h0) ? DUMMY_DEFAULT : {3'h0, i_dummy_cycles};
        end
    end

    // ------------------------------------------------------------
    // Link clock: input side
    // ------------------------------------------------------------
    // Link state clears with select high or during a pin reset
    wire link_clr_n = i_rstn & ~i_cs_n & ~o_hw_reset;
    wire [2:0]  step    = cfg_quad ? STEP_QUAD : STEP_SER;
    wire [6:0]  opc_clk = cfg_quad ? OPC_CLK_QUAD : OPC_CLK_SER;
    wire [6:0]  hdr_end = opc_clk + (cfg_quad ? HDR_CLK_QUAD : HDR_CLK_SER);
    wire        shifting = clk_cnt < hdr_end;
    wire [23:0] next_sh = !shifting ? shin :
                          cfg_quad ? {shin[19:0], i_io_in} : {shin[22:0], i_io_in[0]};
    wire        op_done = clk_cnt == opc_clk - 7'h01;
    wire [7:0]  next_op = op_done ? next_sh[7:0] : opcode;

    // Clocks before the first output bit, per command
    wire [6:0] start_clk =
        (next_op == OP_SIGNATURE) ? hdr_end :
        (next_op == OP_IDENT || next_op == OP_IDENT_QUAD) ? opc_clk :
        (next_op == OP_MAKER_DEV) ? hdr_end :
        hdr_end + cfg_dummy;

    // Commands that return data, and whether this one may
    wire sn_ok    = next_sh[SN_ZERO_HI:SN_ZERO_LO] == 5'h00;
    wire out_ok   = ~cfg_refuse & (
        ((next_op == OP_SIGNATURE) & ~cfg_busy) |
        ((next_op == OP_IDENT) & ~cfg_quad) |
        ((next_op == OP_IDENT_QUAD) & cfg_quad) |
        (next_op == OP_MAKER_DEV) |
        ((next_op == OP_SERIAL) & sn_ok) |
        (next_op == OP_DISCOVERY));
    wire [3:0] first_idx = (next_op == OP_MAKER_DEV) ? {3'h0, next_sh[0]} :
                           (next_op == OP_SERIAL || next_op == OP_DISCOVERY) ?
                           next_sh[3:0] : 4'h0;
    wire go       = ~out_on & (clk_cnt == start_clk - 7'h01) & out_ok;
    wire byte_end = out_on & (bit_ptr == 3'h0 - step);
    wire [3:0] next_idx = (byte_idx == last_of(opcode)) ? 4'h0 : byte_idx + 4'h1;

    // Opcode and toggle survive select high for the main clock
    always_ff @(posedge i_sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            opcode <= OP_NOP;
            shin   <= 24'h000000;
            op_tog <= 1'b0;
        end else begin
            opcode <= next_op;
            shin   <= next_sh;
            op_tog <= op_done & ~i_cs_n ? ~op_tog : op_tog;
        end
    end

    // Frame position and output stream position
    always_ff @(posedge i_sclk or negedge link_clr_n) begin
        if (!link_clr_n) begin
            clk_cnt  <= 7'h00;
            out_on   <= 1'b0;
            bit_ptr  <= 3'h0;
            byte_idx <= 4'h0;
        end else begin
            clk_cnt  <= (clk_cnt == CNT_MAX) ? clk_cnt : clk_cnt + 7'h01;
            out_on   <= out_on | go;
            bit_ptr  <= out_on ? bit_ptr + step : 3'h0;
            byte_idx <= go ? first_idx : byte_end ? next_idx : byte_idx;
        end
    end

    // ------------------------------------------------------------
    // Link clock: output side, falling edge
    // ------------------------------------------------------------
    wire [7:0] cur_byte = byte_of(opcode, byte_idx);
    wire       ser_bit  = cur_byte[3'h7 - bit_ptr];
    wire [3:0] quad_nib = bit_ptr[2] ? cur_byte[3:0] : cur_byte[7:4];

    // Drive MSB first on falling edges
    always_ff @(negedge i_sclk or negedge link_clr_n) begin
        if (!link_clr_n) begin
            o_io_out <= 4'h0;
            o_io_oe  <= 4'h0;
        end else begin
            o_io_out <= cfg_quad ? quad_nib : {2'h0, ser_bit, 1'b0};
            o_io_oe  <= !out_on ? 4'h0 : cfg_quad ? OE_QUAD : OE_SER;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_arm_before_reset: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        o_sw_reset |-> $past(o_reset_armed, 2) && $past(accept))
        else $error("software reset without arm");

    a_nop_disarms: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        accept && opcode == OP_NOP |=> !o_reset_armed && !o_sw_reset && !o_pd_release)
        else $error("no-operation had an effect besides disarm");

    a_pin_width: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        $rose(o_hw_reset) |-> $past(pin_low, 1) && $past(pin_low, 9))
        else $error("pin reset shorter than minimum");

    a_shared_pin_quad: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        pin_s2 == 2'h2 && (i_quad_mode || i_quad_enable || !i_pin_function_select)
        |-> !pin_low)
        else $error("shared pin reset outside serial reset mode");

    a_reset_reload: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        sw_fire |=> o_reload_volatile && !o_reload_locks)
        else $error("software reset reload wrong");

    a_abort_long: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        reset_evt && write_in_progress_flag |=> o_abort_write && rec_cnt == 16'(ABORT_RECOVERY_CYC))
        else $error("write abort not signalled");

    a_row_busy: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        prog && write_in_progress_flag |=> o_info_prog_reject && !o_info_prog_start)
        else $error("row program taken while busy");

    a_row_locked: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        o_info_prog_start |-> !i_info_row_lock[o_info_row])
        else $error("locked row programmed");

    a_sig_busy: assert property (@(posedge i_sclk) disable iff (!link_clr_n)
        out_on && opcode == OP_SIGNATURE |-> !cfg_busy)
        else $error("signature sent while busy");

    a_ident_loop: assert property (@(posedge i_sclk) disable iff (!link_clr_n)
        byte_end && opcode == OP_IDENT && byte_idx == 4'h2 |=> byte_idx == 4'h0)
        else $error("identifier sequence did not restart");

    a_serial_addr: assert property (@(posedge i_sclk) disable iff (!link_clr_n)
        $rose(out_on) && opcode == OP_SERIAL |-> shin[8:4] == 5'h00)
        else $error("serial number with bad address");

endmodule : flash_id_reset_command_unit

`default_nettype wire

// File: flash_id_pkg.sv
// Constants for the flash identification and reset command unit
package flash_id_pkg;

    // ------------------------------------------------------------
    // Command opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_SIGNATURE  = 8'hab;
    localparam logic [7:0] OP_IDENT      = 8'h9f;
    localparam logic [7:0] OP_IDENT_QUAD = 8'haf;
    localparam logic [7:0] OP_MAKER_DEV  = 8'h90;
    localparam logic [7:0] OP_SERIAL     = 8'h4b;
    localparam logic [7:0] OP_DISCOVERY  = 8'h5a;
    localparam logic [7:0] OP_NOP        = 8'h00;
    localparam logic [7:0] OP_ARM        = 8'h66;
    localparam logic [7:0] OP_RESET      = 8'h99;
    localparam logic [7:0] OP_ROW_PROG   = 8'h62;

    // ------------------------------------------------------------
    // Frame layout, in link clocks
    // ------------------------------------------------------------
    localparam logic [6:0] OPC_CLK_SER   = 7'h08;  // Opcode, one bit per clock
    localparam logic [6:0] OPC_CLK_QUAD  = 7'h02;  // Opcode, four bits per clock
    localparam logic [6:0] HDR_CLK_SER   = 7'h18;  // Three address or dummy bytes
    localparam logic [6:0] HDR_CLK_QUAD  = 7'h06;
    localparam logic [6:0] DUMMY_DEFAULT = 7'h08;  // Dummy clocks when the setting is 0
    localparam logic [6:0] CNT_MAX       = 7'h7f;
    localparam logic [2:0] STEP_SER      = 3'h1;
    localparam logic [2:0] STEP_QUAD     = 3'h4;
    localparam logic [3:0] OE_SER        = 4'h2;   // Serial output on data line 1
    localparam logic [3:0] OE_QUAD       = 4'hf;

    // ------------------------------------------------------------
    // Stream lengths in bytes
    // ------------------------------------------------------------
    localparam logic [3:0] LEN_SIG   = 4'h1;
    localparam logic [3:0] LEN_IDENT = 4'h3;
    localparam logic [3:0] LEN_MD    = 4'h2;
    localparam logic [3:0] LEN_16    = 4'hf;       // Last index of 16-byte streams

    // ------------------------------------------------------------
    // Address fields
    // ------------------------------------------------------------
    localparam int SN_ZERO_HI  = 8;                // Serial number: must be zero
    localparam int SN_ZERO_LO  = 4;
    localparam int ROW_TOP_LO  = 16;               // Info row: top byte zero
    localparam int ROW_SEL_HI  = 13;               // Row number in the middle byte
    localparam int ROW_SEL_LO  = 12;
    localparam int ROW_GAP_HI  = 11;               // Middle byte low nibble zero
    localparam int ROW_GAP_LO  = 8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int HW_RESET_MIN_NS  = 100;
    localparam int HW_RESET_MIN_CYC = (HW_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVERY_NS      = 35000;
    localparam int RECOVERY_CYC     = RECOVERY_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Discovery table contents, wraps every 16 bytes
    // ------------------------------------------------------------
    localparam logic [7:0] DISC_TABLE [16] = '{
        8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h00, 8'hff,
        8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hff};

endpackage : flash_id_pkg

// File: spi_host_model.sv
// Serial host controller model that drives the link side of the command unit
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    // Link to the device
    output logic            o_sclk,
    output logic            o_cs_n,
    output logic      [3:0] o_io,
    input  wire logic [3:0] i_io
);
    // Idle: select high, clock parked low
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_io   = 4'h0;
    end

    // One frame: opcode and header bits, dummy clocks, then captured read bits
    task automatic xfer(input logic [31:0] tx, input int ntx, input int ndum,
                        input int nrd, output logic [127:0] rd);
        rd = '0;
        o_cs_n = 1'b0;
        for (int i = 0; i < ntx + ndum + nrd; i++) begin
            o_io[0] = (i < ntx) ? tx[31 - i] : ~o_io[0];
            #24 o_sclk = 1'b1;
            if (i >= ntx + ndum) rd = {rd[126:0], i_io[1]};
            #24 o_sclk = 1'b0;
        end
        o_cs_n  = 1'b1;
        o_io[0] = ~o_io[0]; // Released line shows no stale value
        #100;
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the identification and reset command unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import flash_id_pkg::*;
    localparam logic [7:0]   M  = 8'h5c;  // Arbitrary value
    localparam logic [7:0]   D  = 8'h2e;  // Arbitrary value
    localparam logic [15:0]  T  = 16'h4321; // Arbitrary value
    localparam logic [127:0] SN = 128'h00112233445566778899aabbccddeeff;
    logic mclk, rstn, pin_n, hold_n, pfs, write_in_progress_flag, sclk, cs_n, armed, sw_reset, hw_reset, rec;
    logic [3:0] io_in, io_out, io_oe, dummy, lock;
    logic [1:0] row;
    logic [7:0] baddr;
    wire  [5:0] ev;
    logic [127:0] rd;
    int fail_count = 0, checks = 0, sw_cnt = 0, seed, s, n;
    int ev_cnt [6];

    // Device under test and host partner
    flash_id_reset_command_unit #(.MAKER_CODE(M), .DEVICE_CODE(D), .TYPE_CAPACITY(T),
        .SERIAL_NUMBER(SN), .ABORT_RECOVERY_CYC(20)) dut (.i_mclk(mclk), .i_rstn(rstn),
        .i_sclk(sclk), .i_cs_n(cs_n), .i_io_in(io_in), .o_io_out(io_out), .o_io_oe(io_oe),
        .i_reset_pin_n(pin_n), .i_hold_reset_pin_n(hold_n), .i_quad_mode(1'b0),
        .i_quad_enable(1'b0), .i_pin_function_select(pfs), .i_dedicated_reset_disable(1'b0),
        .i_write_in_progress(write_in_progress_flag), .i_dummy_cycles(dummy), .i_info_row_lock(lock),
        .o_reset_armed(armed), .o_sw_reset(sw_reset), .o_hw_reset(hw_reset),
        .o_reload_volatile(ev[0]), .o_reload_locks(ev[1]), .o_abort_write(ev[2]),
        .o_recovery(rec), .o_pd_release(ev[3]), .o_info_prog_start(ev[4]),
        .o_info_prog_reject(ev[5]), .o_info_row(row), .o_info_byte_addr(baddr));
    // Released data line floats to its pull-up level
    spi_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_io(io_in),
        .i_io(io_oe[1] ? io_out : 4'hf));

    // Clock, software reset and event pulse counters
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (sw_reset === 1'b1) sw_cnt <= sw_cnt + 1;
        for (int k = 0; k < 6; k++) if (ev[k] === 1'b1) ev_cnt[k] <= ev_cnt[k] + 1;
    end

    // Expected serial number stream from a start byte
    function automatic logic [127:0] sn_rot(input logic [3:0] st);
        logic [255:0] d;
        d = {SN, SN};
        return d[255 - 8 * st -: 128];
    endfunction : sn_rot
    // Expected four discovery table bytes from a start byte
    function automatic logic [31:0] disc(input logic [3:0] st);
        logic [31:0] r;
        r = '0;
        for (int k = 0; k < 4; k++) r = {r[23:0], DISC_TABLE[4'(st + k)]};
        return r;
    endfunction : disc

    task automatic results();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t %s", $time, what);
        end
        $display("test %s ended", what);
    endtask : chk
    // Host waits out the recovery time, bounded
    task automatic wait_rec();
        for (n = 0; n < 5000 && rec !== 1'b0; n++) @(posedge mclk);
        chk(n < 5000, 1'b1, "recovery end");
        if (n >= 5000) results();
    endtask : wait_rec

    // Main sequence
    initial begin
        seed = 25388;
        {rstn, write_in_progress_flag, dummy, lock, pin_n, hold_n, pfs} = 13'h006;
        repeat (20) @(posedge mclk);
        #1 rstn = 1'b1;
        repeat (5) @(posedge mclk);
        host.xfer({OP_IDENT, 24'h0}, 8, 0, 48, rd);
        chk(rd[47:0], {2{M, T}}, "ident loop");
        host.xfer({OP_SIGNATURE, 24'h0}, 32, 0, 16, rd);
        chk(rd[15:0], {2{D}}, "signature");
        chk(ev_cnt[3], 1, "wake");
        @(posedge mclk);
        #1 write_in_progress_flag = 1'b1;
        repeat (3) @(posedge mclk);
        host.xfer({OP_SIGNATURE, 24'h0}, 32, 0, 16, rd);
        chk({ev_cnt[3], rd[15:0]}, {32'd1, 16'hffff}, "signature busy");
        host.xfer({OP_ROW_PROG, 24'h0010c3}, 32, 0, 0, rd);
        chk({ev_cnt[4], ev_cnt[5]}, {32'd0, 32'd1}, "row busy");
        @(posedge mclk);
        #1 write_in_progress_flag = 1'b0;
        for (int i = 0; i < 2; i++) begin
            host.xfer({OP_MAKER_DEV, 23'h0, i[0]}, 32, 0, 32, rd);
            chk(rd[31:0], i ? {2{D, M}} : {2{M, D}}, "maker dev");
        end
        repeat (3) begin
            s = $random(seed);
            @(posedge mclk);
            #1 dummy = 4'($random(seed));
            lock = 4'($random(seed));
            repeat (3) @(posedge mclk);
            host.xfer({OP_SERIAL, 15'($random(seed)), 5'h0, s[3:0]}, 32,
                      (dummy == 0) ? 8 : dummy, 128, rd);
            chk(rd, sn_rot(s[3:0]), "serial number");
        end
        @(posedge mclk);
        #1 dummy = 4'h0;
        lock = 4'h4;
        repeat (3) @(posedge mclk);
        host.xfer({OP_DISCOVERY, 20'h0, s[3:0]}, 32, 8, 32, rd);
        chk(rd[31:0], disc(s[3:0]), "discovery");
        host.xfer({OP_ROW_PROG, 24'h0020c3}, 32, 0, 0, rd);
        host.xfer({OP_ROW_PROG, 24'h0018c3}, 32, 0, 0, rd);
        chk(ev_cnt[5], 3, "row refused");
        host.xfer({OP_ROW_PROG, 24'h0010c3}, 32, 0, 0, rd);
        chk({ev_cnt[4], row, baddr}, {32'd1, 2'h1, 8'hc3}, "row program");
        host.xfer({OP_ARM, 24'h0}, 8, 0, 0, rd);
        chk(armed, 1'b1, "armed");
        host.xfer({OP_NOP, 24'h0}, 8, 0, 0, rd);
        host.xfer({OP_RESET, 24'h0}, 8, 0, 0, rd);
        chk(sw_cnt, 0, "nop disarms");
        host.xfer({OP_ARM, 24'h0}, 8, 0, 0, rd);
        host.xfer({OP_RESET, 24'h0}, 8, 0, 0, rd);
        chk(sw_cnt, 1, "soft reset");
        chk({ev_cnt[0], ev_cnt[1]}, {32'd1, 32'd0}, "soft reload");
        wait_rec();
        #1 write_in_progress_flag = 1'b1;
        repeat (3) @(posedge mclk);
        host.xfer({OP_ARM, 24'h0}, 8, 0, 0, rd);
        host.xfer({OP_RESET, 24'h0}, 8, 0, 0, rd);
        chk({sw_cnt, ev_cnt[2]}, {32'd2, 32'd1}, "abort");
        wait_rec();
        @(posedge mclk);
        #1 {write_in_progress_flag, pin_n} = 2'b00;
        repeat (16) @(posedge mclk);
        chk({hw_reset, io_oe}, 5'h10, "pin reset");
        chk(ev_cnt[1], 1, "pin reload");
        #1 pin_n = 1'b1;
        wait_rec();
        #1 hold_n = 1'b0;
        repeat (16) @(posedge mclk);
        chk(hw_reset, 1'b0, "hold pin");
        #1 pfs = 1'b1;
        repeat (16) @(posedge mclk);
        chk(hw_reset, 1'b1, "shared pin reset");
        #1 {pfs, hold_n} = 2'b01;
        wait_rec();
        host.xfer({OP_IDENT, 24'h0}, 8, 0, 24, rd);
        chk(rd[23:0], {M, T}, "ident after reset");
        results();
    end
endmodule : testbench
`default_nettype wire
